/* File: hw/asb_regs.svh */
// Register map, field positions, reset values and capacities of the sample buffer.
// Assumes it is included by bare name; holds definitions only.
`ifndef ASB_REGS_SVH
`define ASB_REGS_SVH

`define ASB_ADDR_THRESHOLD 7'h32
`define ASB_ADDR_MODE_CTRL 7'h33
`define ASB_ADDR_LEVEL 7'h34
`define ASB_ADDR_TRIG_STATUS 7'h35
`define ASB_ADDR_CLEAR 7'h36
`define ASB_ADDR_READ_PORT 7'h7F

`define ASB_READ_BIT 7
`define ASB_ENABLE_BIT 7
`define ASB_RES_BIT 6
`define ASB_TRIG_FLAG_BIT 7

`define ASB_RST_THRESHOLD 8'h00
`define ASB_RST_MODE_CTRL 8'h00

`define ASB_CAP_HI 7'h29
`define ASB_CAP_LO 7'h54
`define ASB_DEPTH 84
`define ASB_BYTES_HI 8'h06
`define ASB_BYTES_LO 8'h03
`define ASB_SET_LAST_HI 3'h5
`define ASB_SET_LAST_LO 3'h2
`define ASB_SPI_BIT_LAST 3'h7
`define ASB_SKID_DEPTH 2

`endif

/* File: hw/asb_pkg.sv */
// Types shared by the sample buffer modules.
// Assumes nothing beyond a SystemVerilog compiler.
package asb_pkg;

    typedef enum logic [1:0] {MODE_FIFO, MODE_STREAM, MODE_TRIG, MODE_LIFO} asb_mode_t;

    typedef enum logic [1:0] {PH_CMD, PH_WRITE, PH_READ} asb_phase_t;

    typedef struct packed {
        logic signed [11:0] x;
        logic signed [11:0] y;
        logic signed [11:0] z;
    } asb_sample_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } asb_spi_in_t;

    typedef struct packed {
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_d;
        logic cs_s1;
        logic cs_s2;
        logic mosi_s1;
        logic mosi_s2;
        asb_phase_t phase;
        logic [2:0] bit_cnt;
        logic [7:0] rx;
        logic [7:0] tx;
        logic [6:0] addr;
        logic load_pend;
        logic [2:0] byte_idx;
        logic [6:0] threshold;
        logic enable;
        logic res;
        asb_mode_t mode;
        logic [6:0] wr_ptr;
        logic [6:0] rd_ptr;
        logic [6:0] count;
        logic trig_seen;
        logic watermark;
        logic miso_oe_n;
    } asb_state_t;

endpackage: asb_pkg

/* File: hw/asb_skid.sv */
// Small valid/ready buffer in front of the sample store.
// Assumes one clock domain; the drain side may stall for any time.
`timescale 1ns/1ns
module asb_skid #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 2
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [CW-1:0] cnt;
        logic ready;
    } asb_skid_state_t;

    asb_skid_state_t st;
    asb_skid_state_t nx;
    logic [WIDTH-1:0] slots [DEPTH];
    logic push;
    logic pull;

    function automatic logic [PW-1:0] slot_inc(input logic [PW-1:0] p);
        slot_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction: slot_inc

    always_comb
    begin
        nx = st;
        push = in_valid && st.ready;
        pull = out_ready && (st.cnt != '0);
        if (push)
        begin
            nx.wr = slot_inc(st.wr);
        end
        if (pull)
        begin
            nx.rd = slot_inc(st.rd);
        end
        nx.cnt = CW'(st.cnt + CW'(push) - CW'(pull));
        // Registered ready: full is known one edge ahead
        nx.ready = (nx.cnt != CW'(DEPTH));
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st <= '0;
            st.ready <= 1'b1;
        end
        else
        begin
            st <= nx;
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            slots[st.wr] <= in_data;
        end
    end

    assign in_ready = st.ready;
    assign out_valid = (st.cnt != '0);
    assign out_data = slots[st.rd];

endmodule: asb_skid

/* File: hw/asb_top.sv */
// Sample buffer of a three-axis accelerometer with its SPI register slave.
// Assumes SPI mode 0 (sample on rising SCLK), SCLK far slower than clk,
// and one sample set per sample_valid pulse at the output data rate.
//
// Operation
// - Threshold is limited to 41 sets at 12-bit, 84 sets at 8-bit.
// - Threshold sets watermark level, or pre-trigger depth in trigger mode; unused when off.
// - Enable bit turns the buffer on when one, off when zero.
// - Resolution bit selects 8-bit sets at zero, 12-bit sets at one.
// - Mode field: 00 fifo, 01 stream, 10 trigger, 11 lifo.
// - Fifo mode fills to capacity then stops storing.
// - Stream mode keeps newest sets, dropping oldest when full.
// - Trigger mode keeps threshold sets before trigger, then fills until full.
// - Lifo mode drops oldest when full and reads newest first.
// - Level register shows stored bytes: six or three per set.
// - Trigger status top bit shows trigger seen in trigger mode; others zero.
// - Any write to clear register empties buffer, and status unless a trigger arrives in that same cycle.
// - Buffer read port streams formatted sets while the host keeps clocking.
// - No sets are stored while a buffer read is in progress.
// - Buffer bytes are two's complement.
// - Watermark stands while the buffer is on and stored sets are at or above a nonzero threshold, outside trigger mode.
// - Sets enter at the output data rate.
`timescale 1ns/1ns
`include "asb_regs.svh"
module asb_top
    import asb_pkg::*;
#(
    parameter int DEPTH = `ASB_DEPTH
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire asb_spi_in_t spi_in,
    output logic spi_miso,
    output logic spi_miso_oe_n,
    input wire asb_sample_t sample_in,
    input wire logic sample_valid,
    output logic sample_ready,
    input wire logic trigger_event,
    output logic watermark
);
    localparam int SET_W = $bits(asb_sample_t);
    localparam logic [7:0] MODE_RST = `ASB_RST_MODE_CTRL;
    localparam logic [7:0] TH_RST = `ASB_RST_THRESHOLD;

    asb_state_t st;
    asb_state_t nx;
    asb_sample_t mem [DEPTH];
    asb_sample_t drain_data;
    asb_sample_t rd_sample;
    logic drain_valid;
    logic drain_ready;
    logic take_sample;
    logic store_en;
    logic drop_old;
    logic pop_set;
    logic clear_cmd;
    logic reading_buf;
    logic sclk_rise;
    logic sclk_fall;
    logic [7:0] byte_in;
    logic [7:0] rd_byte;
    logic [6:0] cap;
    logic [6:0] th_eff;

    function automatic logic [6:0] ptr_inc(input logic [6:0] p);
        ptr_inc = (p == 7'(DEPTH - 1)) ? 7'h00 : 7'(p + 7'h01);
    endfunction: ptr_inc
    function automatic logic [6:0] ptr_dec(input logic [6:0] p);
        ptr_dec = (p == 7'h00) ? 7'(DEPTH - 1) : 7'(p - 7'h01);
    endfunction: ptr_dec
    function automatic logic [6:0] cap_of(input logic res);
        cap_of = res ? `ASB_CAP_HI : `ASB_CAP_LO;
    endfunction: cap_of
    function automatic logic [6:0] clip_th(input logic [6:0] th, input logic res);
        clip_th = (th > cap_of(res)) ? cap_of(res) : th;
    endfunction: clip_th
    function automatic logic [7:0] level_of(input logic [6:0] cnt, input logic res);
        logic [15:0] prod;
        prod = {9'h000, cnt} * {8'h00, (res ? `ASB_BYTES_HI : `ASB_BYTES_LO)};
        level_of = prod[7:0];
    endfunction: level_of
    // Sample words are kept signed, so each byte stays two's complement
    function automatic logic [7:0] set_byte(input asb_sample_t s, input logic [2:0] idx, input logic res);
        logic [2:0] axis;
        logic [11:0] ax;
        axis = res ? {1'b0, idx[2:1]} : idx;
        case (axis)
            3'h0: ax = s.x;
            3'h1: ax = s.y;
            default: ax = s.z;
        endcase
        set_byte = (res && !idx[0]) ? {ax[3:0], 4'h0} : ax[11:4];
    endfunction: set_byte

    // Depth two is enough: a read of one set at the slowest SCLK
    // is far shorter than two sample periods
    asb_skid #(
        .WIDTH(SET_W),
        .DEPTH(`ASB_SKID_DEPTH)
    ) u_skid (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_data(sample_in),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .out_data(drain_data),
        .out_valid(drain_valid),
        .out_ready(drain_ready)
    );

    assign sclk_rise = st.sclk_s2 && !st.sclk_d;
    assign sclk_fall = !st.sclk_s2 && st.sclk_d;
    assign cap = cap_of(st.res);
    assign th_eff = clip_th(st.threshold, st.res);
    assign reading_buf = !st.cs_s2 && (st.phase == PH_READ) && (st.addr == `ASB_ADDR_READ_PORT);
    assign drain_ready = !reading_buf;

    always_comb
    begin
        rd_sample = (st.mode == MODE_LIFO) ? mem[ptr_dec(st.wr_ptr)] : mem[st.rd_ptr];
        case (st.addr)
            `ASB_ADDR_THRESHOLD: rd_byte = {1'b0, st.threshold};
            `ASB_ADDR_MODE_CTRL: rd_byte = {st.enable, st.res, 4'h0, st.mode};
            `ASB_ADDR_LEVEL: rd_byte = level_of(st.count, st.res);
            `ASB_ADDR_TRIG_STATUS: rd_byte = {(st.mode == MODE_TRIG) && st.trig_seen, 7'h00};
            `ASB_ADDR_READ_PORT: rd_byte = (|st.count) ? set_byte(rd_sample, st.byte_idx, st.res) : 8'h00;
            default: rd_byte = 8'h00;
        endcase
    end

    always_comb
    begin
        nx = st;
        byte_in = {st.rx[6:0], st.mosi_s2};
        store_en = 1'b0;
        drop_old = 1'b0;
        pop_set = 1'b0;
        clear_cmd = 1'b0;
        take_sample = 1'b0;
        nx.sclk_s1 = spi_in.sclk;
        nx.sclk_s2 = st.sclk_s1;
        nx.sclk_d = st.sclk_s2;
        nx.cs_s1 = spi_in.cs_n;
        nx.cs_s2 = st.cs_s1;
        nx.mosi_s1 = spi_in.mosi;
        nx.mosi_s2 = st.mosi_s1;

        if (st.cs_s2)
        begin
            // A partly read set is not consumed
            nx.phase = PH_CMD;
            nx.bit_cnt = 3'h0;
            nx.byte_idx = 3'h0;
            nx.load_pend = 1'b0;
        end
        else
        begin
            if (st.load_pend)
            begin
                nx.load_pend = 1'b0;
                nx.tx = rd_byte;
            end
            if (sclk_rise)
            begin
                nx.rx = byte_in;
                nx.bit_cnt = 3'(st.bit_cnt + 3'h1);
                if (st.bit_cnt == `ASB_SPI_BIT_LAST)
                begin
                    case (st.phase)
                        PH_CMD:
                        begin
                            nx.addr = byte_in[6:0];
                            nx.phase = byte_in[`ASB_READ_BIT] ? PH_READ : PH_WRITE;
                            nx.load_pend = byte_in[`ASB_READ_BIT];
                        end
                        PH_WRITE:
                        begin
                            case (st.addr)
                                `ASB_ADDR_THRESHOLD: nx.threshold = byte_in[6:0];
                                `ASB_ADDR_MODE_CTRL:
                                begin
                                    nx.enable = byte_in[`ASB_ENABLE_BIT];
                                    nx.res = byte_in[`ASB_RES_BIT];
                                    nx.mode = asb_mode_t'(byte_in[1:0]);
                                end
                                `ASB_ADDR_CLEAR: clear_cmd = 1'b1;
                                default: ;
                            endcase
                            nx.addr = 7'(st.addr + 7'h01);
                        end
                        PH_READ:
                        begin
                            nx.load_pend = 1'b1;
                            if (st.addr == `ASB_ADDR_READ_PORT)
                            begin
                                // The read port never advances; sets keep coming
                                if (st.byte_idx == (st.res ? `ASB_SET_LAST_HI : `ASB_SET_LAST_LO))
                                begin
                                    nx.byte_idx = 3'h0;
                                    pop_set = 1'b1;
                                end
                                else
                                begin
                                    nx.byte_idx = 3'(st.byte_idx + 3'h1);
                                end
                            end
                            else
                            begin
                                nx.addr = 7'(st.addr + 7'h01);
                            end
                        end
                        default: nx.phase = PH_CMD;
                    endcase
                end
            end
            if (sclk_fall && (st.bit_cnt != 3'h0))
            begin
                nx.tx = {st.tx[6:0], 1'b0};
            end
        end

        take_sample = drain_valid && drain_ready && st.enable;
        if (take_sample)
        begin
            case (st.mode)
                MODE_FIFO: store_en = (st.count < cap);
                MODE_TRIG:
                begin
                    if (st.trig_seen)
                    begin
                        store_en = (st.count < cap);
                    end
                    else
                    begin
                        store_en = (th_eff != 7'h00);
                        drop_old = (st.count >= th_eff);
                    end
                end
                default:
                begin
                    store_en = 1'b1;
                    drop_old = (st.count >= cap);
                end
            endcase
        end
        if (store_en)
        begin
            nx.wr_ptr = ptr_inc(st.wr_ptr);
            nx.rd_ptr = drop_old ? ptr_inc(st.rd_ptr) : nx.rd_ptr;
            nx.count = drop_old ? nx.count : 7'(st.count + 7'h01);
        end
        if (pop_set && (st.count != 7'h00))
        begin
            nx.count = 7'(st.count - 7'h01);
            nx.wr_ptr = (st.mode == MODE_LIFO) ? ptr_dec(st.wr_ptr) : nx.wr_ptr;
            nx.rd_ptr = (st.mode == MODE_LIFO) ? nx.rd_ptr : ptr_inc(st.rd_ptr);
        end
        if (clear_cmd)
        begin
            nx.wr_ptr = 7'h00;
            nx.rd_ptr = 7'h00;
            nx.count = 7'h00;
            nx.trig_seen = 1'b0;
        end
        // Placed after the clear so a trigger in the clear cycle survives
        if (trigger_event && st.enable && (st.mode == MODE_TRIG))
        begin
            nx.trig_seen = 1'b1;
        end
        nx.watermark = st.enable && (st.mode != MODE_TRIG) && (th_eff != 7'h00) && (st.count >= th_eff);
        nx.miso_oe_n = st.cs_s2 || (nx.phase != PH_READ);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st <= '0;
            st.cs_s1 <= 1'b1;
            st.cs_s2 <= 1'b1;
            st.miso_oe_n <= 1'b1;
            st.threshold <= TH_RST[6:0];
            st.enable <= MODE_RST[`ASB_ENABLE_BIT];
            st.res <= MODE_RST[`ASB_RES_BIT];
            st.mode <= asb_mode_t'(MODE_RST[1:0]);
        end
        else
        begin
            st <= nx;
        end
    end

    always_ff @(posedge clk)
    begin
        if (store_en)
        begin
            mem[st.wr_ptr] <= drain_data;
        end
    end

    assign spi_miso = st.tx[7];
    assign spi_miso_oe_n = st.miso_oe_n;
    assign watermark = st.watermark;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_read_active;
        !st.cs_s2 && (st.phase == PH_READ) && (st.addr == `ASB_ADDR_READ_PORT);
    endsequence
    sequence s_full_fifo;
        st.enable && (st.mode == MODE_FIFO) && (st.count >= cap);
    endsequence
    property p_no_store_in_read;
        s_read_active |=> (st.count <= $past(st.count)) && (st.wr_ptr == $past(st.wr_ptr) || st.mode == MODE_LIFO);
    endproperty

    a_thr_clip_cap: assert property (th_eff <= cap)
        else $error("effective threshold above capacity");
    a_bypass_no_store: assert property (!st.enable |-> !store_en)
        else $error("set stored while buffer is off");
    a_fifo_stops_full: assert property (s_full_fifo ##1 $stable(st.res) |-> st.count <= $past(st.count))
        else $error("fifo grew past capacity");
    a_stream_keeps_full: assert property ((st.mode == MODE_STREAM) && (st.count == cap) && store_en
        |=> (st.count == $past(st.count)) && (st.rd_ptr == ptr_inc($past(st.rd_ptr))))
        else $error("stream did not drop oldest when full");
    a_trig_pre_depth: assert property ((st.mode == MODE_TRIG) && !st.trig_seen && store_en
        && (st.count >= th_eff) |=> st.count == $past(st.count))
        else $error("pre-trigger history grew past threshold");
    a_lifo_pop_newest: assert property ((st.mode == MODE_LIFO) && pop_set && (st.count != 7'h00)
        |=> (st.wr_ptr == ptr_dec($past(st.wr_ptr))) && $stable(st.rd_ptr))
        else $error("lifo pop did not take newest set");
    a_level_bytes: assert property (st.addr == `ASB_ADDR_LEVEL
        |-> rd_byte == (st.res ? 8'(st.count * 6) : 8'(st.count * 3)))
        else $error("level byte count wrong");
    a_trig_status_bits: assert property (st.addr == `ASB_ADDR_TRIG_STATUS
        |-> (rd_byte[6:0] == 7'h00) && (rd_byte[7] == ((st.mode == MODE_TRIG) && st.trig_seen)))
        else $error("trigger status byte wrong");
    a_clear_empties: assert property (clear_cmd |=> (st.count == 7'h00) && (st.wr_ptr == st.rd_ptr)
        && (!st.trig_seen || $past(trigger_event)))
        else $error("clear left buffer state");
    a_no_store_read: assert property (p_no_store_in_read)
        else $error("set stored during buffer read");
    a_miso_release: assert property ($rose(st.cs_s2) |=> spi_miso_oe_n [*2])
        else $error("miso still driven after deselect");
    a_wm_follows: assert property (st.enable && (st.mode != MODE_TRIG)
        && (th_eff != 7'h00) && (st.count >= th_eff) |=> watermark)
        else $error("watermark missing at threshold");
    a_wm_drops: assert property ((st.count < th_eff) |=> !watermark)
        else $error("watermark held below threshold");

endmodule: asb_top

/* File: dv/asb_spi_host.sv */
// SPI mode 0 host model that reaches the sample buffer registers.
// Assumes a 100 ns bench clock; SCLK half period is four clocks (400 ns).
`timescale 1ns/1ns
`include "asb_regs.svh"
module asb_spi_host
    import asb_pkg::*;
(
    input wire logic clk,
    output asb_spi_in_t spi,
    input wire logic miso,
    input wire logic miso_oe_n
);
    initial spi = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};

    task automatic half_wait;
        repeat (4) @(posedge clk);
    endtask: half_wait

    // Clock stands low outside frames
    task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            spi.mosi <= tx[i];
            half_wait();
            spi.sclk <= 1'b1;
            rx[i] = (miso_oe_n === 1'b0) ? miso : 1'bx;
            half_wait();
            spi.sclk <= 1'b0;
        end
    endtask: xfer_byte

    task automatic frame_begin(input logic [7:0] cmd);
        logic [7:0] unused;
        spi.cs_n <= 1'b0;
        half_wait();
        xfer_byte(cmd, unused);
    endtask: frame_begin

    // Mosi flips once deselected, so a stale level is never trusted
    task automatic frame_end;
        half_wait();
        spi.cs_n <= 1'b1;
        spi.mosi <= ~spi.mosi;
        repeat (8) @(posedge clk);
    endtask: frame_end

    task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
        logic [7:0] unused;
        frame_begin({1'b0, addr});
        xfer_byte(data, unused);
        frame_end();
    endtask: write_reg

    task automatic read_reg(input logic [6:0] addr, output logic [7:0] data);
        frame_begin({1'b1, addr});
        xfer_byte(8'h00, data);
        frame_end();
    endtask: read_reg

    // Whole sets only, one frame each
    task automatic read_set(input logic hi, output logic [7:0] rx [6]);
        for (int k = 0; k < 6; k++)
            rx[k] = 8'h00;
        frame_begin({1'b1, `ASB_ADDR_READ_PORT});
        for (int k = 0; k < (hi ? 6 : 3); k++)
            xfer_byte(8'h00, rx[k]);
        frame_end();
    endtask: read_set
endmodule: asb_spi_host

/* File: dv/tb_accel_sample_buffer.sv */
// Self-checking bench of the sample buffer: modes, levels, flags, read order.
// Assumes asb_top with default depth and the SPI host model beside it.
`timescale 1ns/1ns
`include "asb_regs.svh"
module tb_accel_sample_buffer
    import asb_pkg::*;
;
    logic clk;
    logic sys_rst;
    asb_spi_in_t spi;
    logic spi_miso;
    logic spi_miso_oe_n;
    asb_sample_t sample_in;
    logic sample_valid;
    logic sample_ready;
    logic trigger_event;
    logic watermark;
    int seed = 32'h3f2fb797;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    asb_sample_t hist[$];
    logic [7:0] d;

    asb_top u_dut (.clk(clk), .sys_rst(sys_rst), .spi_in(spi), .spi_miso(spi_miso),
        .spi_miso_oe_n(spi_miso_oe_n), .sample_in(sample_in), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .trigger_event(trigger_event), .watermark(watermark));

    asb_spi_host u_host (.clk(clk), .spi(spi), .miso(spi_miso), .miso_oe_n(spi_miso_oe_n));

    always #50 clk = ~clk;

    task automatic complete_run;
        if (err_total == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask: complete_run

    // Hang guard, far above the few thousand cycles the run needs
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            err_total++;
            complete_run();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask: check

    task automatic push(input int n);
        asb_sample_t s;
        int w;
        for (int i = 0; i < n; i++)
        begin
            s = asb_sample_t'(36'({$random(seed), $random(seed)}));
            hist.push_back(s);
            sample_in <= s;
            sample_valid <= 1'b1;
            @(posedge clk);
            w = 0;
            while (sample_ready !== 1'b1 && w < 50)
            begin
                @(posedge clk);
                w++;
            end
            sample_valid <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask: push

    function automatic logic [7:0] exp_byte(asb_sample_t s, logic hi, int k);
        logic [11:0] ax [3];
        ax = '{s.x, s.y, s.z};
        if (hi)
            return (k % 2) ? ax[k / 2][11:4] : {ax[k / 2][3:0], 4'h0};
        return ax[k][11:4];
    endfunction: exp_byte

    task automatic check_set(input asb_sample_t s, input logic hi);
        logic [7:0] rx [6];
        u_host.read_set(hi, rx);
        for (int k = 0; k < (hi ? 6 : 3); k++)
            check(rx[k], exp_byte(s, hi, k));
    endtask: check_set

    task automatic level_is(input logic [7:0] exp);
        u_host.read_reg(`ASB_ADDR_LEVEL, d);
        check(d, exp);
    endtask: level_is

    task automatic restart(input logic [7:0] mode);
        u_host.write_reg(`ASB_ADDR_CLEAR, 8'($random(seed)));
        u_host.write_reg(`ASB_ADDR_MODE_CTRL, mode);
        hist.delete();
    endtask: restart

    initial
    begin
        clk = 1'b0;
        sys_rst = 1'b1;
        sample_in = '0;
        sample_valid = 1'b0;
        trigger_event = 1'b0;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        u_host.read_reg(`ASB_ADDR_THRESHOLD, d);
        check(d, `ASB_RST_THRESHOLD);
        u_host.read_reg(`ASB_ADDR_MODE_CTRL, d);
        check(d, `ASB_RST_MODE_CTRL);
        u_host.read_reg(7'h10, d);
        check(d, 8'h00);
        // Fifo at 12 bit, watermark at three sets
        u_host.write_reg(`ASB_ADDR_THRESHOLD, 8'h03);
        restart(8'hC0);
        push(2);
        check({7'h00, watermark}, 8'h00);
        push(1);
        check({7'h00, watermark}, 8'h01);
        push(45);
        level_is(8'hF6);
        // Oversized threshold must clip to capacity
        u_host.write_reg(`ASB_ADDR_THRESHOLD, 8'h7F);
        check({7'h00, watermark}, 8'h01);
        check_set(hist[0], 1'b1);
        level_is(8'hF0);
        check({7'h00, watermark}, 8'h00);
        u_host.write_reg(`ASB_ADDR_CLEAR, 8'h00);
        level_is(8'h00);
        check({7'h00, watermark}, 8'h00);
        // Stream at 8 bit overflows by six sets
        u_host.write_reg(`ASB_ADDR_THRESHOLD, 8'h03);
        restart(8'h81);
        push(90);
        level_is(8'hFC);
        check_set(hist[6], 1'b0);
        // Lifo returns newest first
        restart(8'h83);
        push(5);
        check_set(hist[4], 1'b0);
        check_set(hist[3], 1'b0);
        level_is(8'h09);
        // Bypass stores nothing; level is read only
        restart(8'h03);
        push(4);
        u_host.write_reg(`ASB_ADDR_LEVEL, 8'h5A);
        level_is(8'h00);
        check({7'h00, watermark}, 8'h00);
        // Trigger with two pre-trigger sets kept
        u_host.write_reg(`ASB_ADDR_THRESHOLD, 8'h02);
        restart(8'h82);
        push(5);
        u_host.read_reg(`ASB_ADDR_TRIG_STATUS, d);
        check(d, 8'h00);
        trigger_event <= 1'b1;
        @(posedge clk);
        trigger_event <= 1'b0;
        repeat (4) @(posedge clk);
        u_host.read_reg(`ASB_ADDR_TRIG_STATUS, d);
        check(d, 8'h80);
        push(3);
        level_is(8'h0F);
        check_set(hist[3], 1'b0);
        u_host.write_reg(`ASB_ADDR_CLEAR, 8'hFF);
        u_host.read_reg(`ASB_ADDR_TRIG_STATUS, d);
        check(d, 8'h00);
        level_is(8'h00);
        // Sets offered during a buffer read wait in the skid buffer, none lost
        restart(8'h81);
        push(2);
        fork
            check_set(hist[0], 1'b0);
            begin
                repeat (100) @(posedge clk);
                push(2);
                check({7'h00, sample_ready}, 8'h00);
            end
        join
        check({7'h00, sample_ready}, 8'h01);
        level_is(8'h09);
        complete_run();
    end
endmodule: tb_accel_sample_buffer
